// *** lrcr_pkg.sv ***
package lrcr_pkg;

  // ==========================================================
  // Widths
  localparam int CONN_W = 4;
  localparam int BUF_W = 8;
  localparam int CNT_W = 16;
  localparam int CHAR_W = 8;
  localparam int PORT_W = 4;
  localparam int FIFO_DEPTH = 32;

  // ==========================================================
  // Synchronised pin inputs
  localparam int SYNC_N = 3;
  localparam int SY_SENSE_A = 0;
  localparam int SY_SENSE_D = 1;
  localparam int SY_RESET = 2;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int RST_HOLD_NS = 1000;
  localparam int RST_HOLD_CYC = (RST_HOLD_NS + CLK_PERIOD_NS - 1) /
                                CLK_PERIOD_NS;
  localparam int HOLD_W = 8;
  localparam logic [HOLD_W-1:0] HOLD_LOAD = HOLD_W'(RST_HOLD_CYC - 1);
  localparam logic [HOLD_W-1:0] HOLD_ZERO = 8'h00;
  localparam logic [HOLD_W-1:0] HOLD_ONE = 8'h01;

  // ==========================================================
  // Reset values and step constants
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [CONN_W-1:0] CONN_ZERO = 4'h0;
  localparam logic [CONN_W-1:0] CONN_STEP = 4'h1;
  localparam logic [BUF_W-1:0] BUF_ZERO = 8'h00;
  localparam logic [CHAR_W-1:0] CHAR_ZERO = 8'h00;

  // ==========================================================
  // Commands, answers, reasons
  typedef enum logic [2:0] {
    CMD_OPEN, CMD_SEND, CMD_RECEIVE, CMD_CLOSE, CMD_RESET
  } lrcr_cmd_e;

  typedef enum logic [2:0] {
    RSP_GOOD, RSP_INVALID_CONN, RSP_INVALID_BUF, RSP_RECEIVE_PENDING,
    RSP_PORT_IN_USE, RSP_INVALID_PORT
  } lrcr_rsp_e;

  typedef enum logic [1:0] {
    RSN_CLOSE_REQUESTED, RSN_CLOSED_STATE, RSN_SENSE_DEASSERTED
  } lrcr_reason_e;

  typedef struct packed {
    lrcr_cmd_e cmd;
    logic [PORT_W-1:0] port;
    logic [CONN_W-1:0] conn;
    logic [BUF_W-1:0] buf_id;
    logic buf_ok;
    logic [CNT_W-1:0] limit;
  } lrcr_req_s;

  typedef struct packed {
    logic [CONN_W-1:0] conn;
    logic [BUF_W-1:0] buf_id;
    logic [CNT_W-1:0] count;
  } lrcr_recv_s;

  typedef struct packed {
    logic [CONN_W-1:0] conn;
    lrcr_reason_e reason;
  } lrcr_closed_s;

endpackage

// *** lrcr_fifo.sv ***
module lrcr_fifo import lrcr_pkg::*; #(
  parameter int WIDTH = CHAR_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
  localparam logic [AW:0] EMPTY = '0;
  localparam logic [AW-1:0] PTR_ONE = AW'(1);
  localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0] level;
  logic push;
  logic pop;

  assign in_ready = level != FULL;
  assign out_valid = level != EMPTY;
  assign out_data = mem[rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wp] <= in_data;
    end
  end

  // ==========================================================
  // Pointers wrap at DEPTH so non power of two depths work
  always_ff @(posedge sys_clk) begin
    if (rst || flush) begin
      wp <= '0;
      rp <= '0;
      level <= EMPTY;
    end else begin
      if (push) begin
        wp <= (wp == PTR_LAST) ? '0 : AW'(wp + PTR_ONE);
      end
      if (pop) begin
        rp <= (rp == PTR_LAST) ? '0 : AW'(rp + PTR_ONE);
      end
      if (push && !pop) begin
        level <= (AW+1)'(level + 1'b1);
      end else if (pop && !push) begin
        level <= (AW+1)'(level - 1'b1);
      end
    end
  end
endmodule

// *** lrcr_port.sv ***
// Operation
// - Second receive while one is pending is answered receive-pending.
// - Never place more characters into the buffer than the size limit.
// - Bad buffer invalid-buffer, unknown connection invalid-connection.
// - Received indication reports connection, buffer and placed count.
// - Characters are handed over still encoded, escapes untouched.
// - Received boundaries are independent of send boundaries.
// - Any send after a close is answered invalid-connection.
// - No received indication after closed until a new connected.
// - Drive-side device closes on falling drive-side cable sense.
// - Library-side device closes on falling library-side cable sense.
// - Closed reason: close-requested, closed-state or sense-deasserted.
// - Closed-state reason only on network variant at transport loss.
// - Close on unestablished connection invalid-connection, otherwise good.
// - Library-side reset request resets port and asserts remote reset.
// - Drive-side port signals reset-received when remote reset asserts.
// - On close, send all accepted characters; later arrivals may drop.
// - Serve receives until buffered characters are delivered, then closed.
module lrcr_port import lrcr_pkg::*; #(
  parameter bit DRIVE_SIDE = 1'b1,
  parameter bit NETWORK_VARIANT = 1'b0,
  parameter logic [PORT_W-1:0] LOCAL_PORT = 4'h0
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic req_valid,
  input wire lrcr_req_s req,
  output logic rsp_valid,
  output lrcr_rsp_e rsp,
  output logic connected_valid,
  output logic [CONN_W-1:0] connected_conn,
  output logic wr_valid,
  input wire logic wr_ready,
  output logic [CHAR_W-1:0] wr_data,
  output logic [CNT_W-1:0] wr_index,
  output logic recv_valid,
  output lrcr_recv_s recv,
  output logic closed_valid,
  output lrcr_closed_s closed,
  output logic reset_rcvd_valid,
  output logic [PORT_W-1:0] reset_rcvd_port,
  input wire logic rx_valid,
  output logic rx_ready,
  input wire logic [CHAR_W-1:0] rx_data,
  input wire logic tx_idle,
  input wire logic cable_sense_a,
  input wire logic cable_sense_d,
  input wire logic transport_lost,
  input wire logic remote_reset_in,
  output logic remote_reset_out
);
  typedef enum logic [1:0] {ST_IDLE, ST_OPEN, ST_CLOSING} lrcr_state_e;

  lrcr_state_e state;
  logic pending;
  logic [CONN_W-1:0] conn_id;
  logic [BUF_W-1:0] buf_q;
  logic [CNT_W-1:0] lim_q;
  logic [CNT_W-1:0] cnt;
  logic [HOLD_W-1:0] hold;
  logic [SYNC_N-1:0] sync_in;
  logic [SYNC_N-1:0] sy1;
  logic [SYNC_N-1:0] sy2;
  logic [SYNC_N-1:0] sy3;
  logic [SYNC_N-1:0] stab;
  logic [SYNC_N-1:0] rise;
  logic [SYNC_N-1:0] fall;
  lrcr_rsp_e next_rsp;
  logic f_iv, f_ir, f_ov, f_flush;
  logic [CHAR_W-1:0] f_data;
  logic port_ok, conn_ok, live;
  logic sense_fall, lost_ev, abort;
  logic lib_reset, rr_event, local_reset;
  logic open_ok, close_ok, recv_good;
  logic take, fin, drained, done;

  // ==========================================================
  // Pin synchronisers: three stages, change taken when 2 and 3 agree
  assign sync_in = {remote_reset_in, cable_sense_d, cable_sense_a};

  generate
    for (genvar i = 0; i < SYNC_N; i++) begin : g_sync
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          sy1[i] <= 1'b0;
          sy2[i] <= 1'b0;
          sy3[i] <= 1'b0;
          stab[i] <= 1'b0;
        end else begin
          sy1[i] <= sync_in[i];
          sy2[i] <= sy1[i];
          sy3[i] <= sy2[i];
          if (sy2[i] == sy3[i]) begin
            stab[i] <= sy3[i];
          end
        end
      end
      assign rise[i] = sy2[i] && sy3[i] && !stab[i];
      assign fall[i] = !sy2[i] && !sy3[i] && stab[i];
    end
  endgenerate

  // ==========================================================
  // Events
  assign port_ok = req.port == LOCAL_PORT;
  assign conn_ok = req.conn == conn_id;
  assign live = (state == ST_OPEN) || (state == ST_CLOSING);
  // Each side watches the sense line driven by its partner
  assign sense_fall = DRIVE_SIDE ? fall[SY_SENSE_A]
                                 : fall[SY_SENSE_D];
  assign lost_ev = NETWORK_VARIANT && transport_lost;
  assign abort = live && (sense_fall || lost_ev);
  assign lib_reset = !DRIVE_SIDE && req_valid && req.cmd == CMD_RESET &&
                     port_ok;
  assign rr_event = DRIVE_SIDE && rise[SY_RESET];
  assign local_reset = lib_reset || rr_event;
  assign open_ok = req_valid && req.cmd == CMD_OPEN &&
                   next_rsp == RSP_GOOD;
  assign close_ok = req_valid && req.cmd == CMD_CLOSE &&
                    next_rsp == RSP_GOOD;
  assign recv_good = req_valid && req.cmd == CMD_RECEIVE &&
                     next_rsp == RSP_GOOD;

  // ==========================================================
  // Answers
  always_comb begin
    next_rsp = RSP_GOOD;
    case (req.cmd)
      CMD_OPEN: begin
        if (!port_ok) begin
          next_rsp = RSP_INVALID_PORT;
        end else if (state != ST_IDLE) begin
          next_rsp = RSP_PORT_IN_USE;
        end
      end
      CMD_SEND: begin
        if (!(state == ST_OPEN && conn_ok)) begin
          next_rsp = RSP_INVALID_CONN;
        end
      end
      CMD_RECEIVE: begin
        if (!req.buf_ok) begin
          next_rsp = RSP_INVALID_BUF;
        end else if (!(live && conn_ok)) begin
          next_rsp = RSP_INVALID_CONN;
        end else if (pending) begin
          next_rsp = RSP_RECEIVE_PENDING;
        end
      end
      CMD_CLOSE: begin
        if (!(state == ST_OPEN && conn_ok)) begin
          next_rsp = RSP_INVALID_CONN;
        end
      end
      CMD_RESET: begin
        if (DRIVE_SIDE || !port_ok) begin
          next_rsp = RSP_INVALID_PORT;
        end
      end
      default: begin
        next_rsp = RSP_INVALID_PORT;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rsp_valid <= 1'b0;
      rsp <= RSP_GOOD;
    end else begin
      rsp_valid <= req_valid;
      rsp <= next_rsp;
    end
  end

  // ==========================================================
  // Connection state
  // Close waits for the transmitter so accepted sends still go out
  assign drained = state == ST_CLOSING && !f_ov && tx_idle &&
                   (!pending || cnt == CNT_ZERO) && !recv_valid &&
                   !fin;
  assign done = drained && !abort && !local_reset;

  always_ff @(posedge sys_clk) begin
    if (rst || local_reset) begin
      state <= ST_IDLE;
    end else if (abort || done) begin
      state <= ST_IDLE;
    end else if (open_ok) begin
      state <= ST_OPEN;
    end else if (close_ok) begin
      state <= ST_CLOSING;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      conn_id <= CONN_ZERO;
      connected_valid <= 1'b0;
    end else begin
      connected_valid <= open_ok && !local_reset;
      if (open_ok && !local_reset) begin
        conn_id <= CONN_W'(conn_id + CONN_STEP);
      end
    end
  end
  assign connected_conn = conn_id;

  // ==========================================================
  // Receive delivery
  // Characters go straight from the FIFO, so escapes stay encoded
  assign take = pending && live && !abort && !local_reset &&
                cnt != lim_q && f_ov && wr_ready;
  // A partial fill is handed over as soon as the FIFO runs dry
  assign fin = pending && live && !abort && !local_reset && !take &&
               (cnt == lim_q || (cnt != CNT_ZERO && !f_ov));

  always_ff @(posedge sys_clk) begin
    if (rst || local_reset || abort || done) begin
      pending <= 1'b0;
    end else if (fin) begin
      pending <= 1'b0;
    end else if (recv_good) begin
      pending <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      buf_q <= BUF_ZERO;
      lim_q <= CNT_ZERO;
      cnt <= CNT_ZERO;
    end else if (recv_good) begin
      buf_q <= req.buf_id;
      lim_q <= req.limit;
      cnt <= CNT_ZERO;
    end else if (take) begin
      cnt <= CNT_W'(cnt + CNT_ONE);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wr_valid <= 1'b0;
      wr_data <= CHAR_ZERO;
      wr_index <= CNT_ZERO;
    end else begin
      wr_valid <= take;
      wr_data <= f_data;
      wr_index <= cnt;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      recv_valid <= 1'b0;
      recv <= '0;
    end else begin
      recv_valid <= fin;
      recv.conn <= conn_id;
      recv.buf_id <= buf_q;
      recv.count <= cnt;
    end
  end

  // ==========================================================
  // Closed indication
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      closed_valid <= 1'b0;
      closed <= '0;
    end else begin
      closed_valid <= !local_reset && (abort || done);
      closed.conn <= conn_id;
      if (sense_fall) begin
        closed.reason <= RSN_SENSE_DEASSERTED;
      end else if (lost_ev) begin
        closed.reason <= RSN_CLOSED_STATE;
      end else begin
        closed.reason <= RSN_CLOSE_REQUESTED;
      end
    end
  end

  // ==========================================================
  // Remote reset
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hold <= HOLD_ZERO;
      remote_reset_out <= 1'b0;
    end else if (lib_reset) begin
      hold <= HOLD_LOAD;
      remote_reset_out <= 1'b1;
    end else if (hold != HOLD_ZERO) begin
      hold <= HOLD_W'(hold - HOLD_ONE);
    end else begin
      remote_reset_out <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reset_rcvd_valid <= 1'b0;
    end else begin
      reset_rcvd_valid <= rr_event;
    end
  end
  assign reset_rcvd_port = LOCAL_PORT;

  // ==========================================================
  // Receive FIFO; arrivals after close are accepted and dropped
  assign f_iv = rx_valid && state == ST_OPEN;
  assign rx_ready = (state == ST_OPEN) ? f_ir : 1'b1;
  assign f_flush = local_reset || abort;

  lrcr_fifo #(.WIDTH(CHAR_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .rst(rst),
    .flush(f_flush),
    .in_valid(f_iv),
    .in_ready(f_ir),
    .in_data(rx_data),
    .out_valid(f_ov),
    .out_ready(take),
    .out_data(f_data)
  );

  // ==========================================================
  // Assertions
  pend_refuse_a: assert property (@(posedge sys_clk) disable iff (rst)
    req_valid && req.cmd == CMD_RECEIVE && req.buf_ok && live && conn_ok &&
    pending |=> rsp_valid && rsp == RSP_RECEIVE_PENDING)
    else $error("pending receive not refused");
  count_limit_a: assert property (@(posedge sys_clk) disable iff (rst)
    recv_valid |-> recv.count <= lim_q)
    else $error("count above limit");
  bad_buffer_a: assert property (@(posedge sys_clk) disable iff (rst)
    req_valid && req.cmd == CMD_RECEIVE && !req.buf_ok
    |=> rsp == RSP_INVALID_BUF)
    else $error("bad buffer not refused");
  recv_count_a: assert property (@(posedge sys_clk) disable iff (rst)
    recv_valid |-> recv.count == cnt && recv.buf_id == buf_q)
    else $error("received fields wrong");
  raw_char_a: assert property (@(posedge sys_clk) disable iff (rst)
    take |=> wr_valid && wr_data == $past(f_data))
    else $error("character altered");
  send_close_a: assert property (@(posedge sys_clk) disable iff (rst)
    req_valid && req.cmd == CMD_SEND && state != ST_OPEN
    |=> rsp == RSP_INVALID_CONN)
    else $error("send after close accepted");
  quiet_close_a: assert property (@(posedge sys_clk) disable iff (rst)
    closed_valid |-> !recv_valid ##1 !recv_valid [*3])
    else $error("received after closed");
  sense_close_a: assert property (@(posedge sys_clk)
    disable iff (rst)
    sense_fall && live && !local_reset
    |=> closed_valid && closed.reason == RSN_SENSE_DEASSERTED)
    else $error("sense fall not closed");
  close_good_a: assert property (@(posedge sys_clk) disable iff (rst)
    req_valid && req.cmd == CMD_CLOSE && state == ST_OPEN && conn_ok
    |=> rsp == RSP_GOOD ##1 (state == ST_CLOSING || closed_valid))
    else $error("close not taken");
  reset_out_a: assert property (@(posedge sys_clk) disable iff (rst)
    lib_reset |=> remote_reset_out [*8] ##0 state == ST_IDLE)
    else $error("remote reset not held");
  reset_rcvd_a: assert property (@(posedge sys_clk) disable iff (rst)
    rr_event |=> reset_rcvd_valid && state == ST_IDLE)
    else $error("reset received missing");
  drain_first_a: assert property (@(posedge sys_clk)
    disable iff (rst)
    closed_valid && closed.reason == RSN_CLOSE_REQUESTED
    |-> !$past(f_ov) && $past(tx_idle))
    else $error("closed before drained");
  one_strobe_a: assert property (@(posedge sys_clk) disable iff (rst)
    recv_valid |=> !recv_valid)
    else $error("received strobe too long");

  recv_full_c: cover property (@(posedge sys_clk) disable iff (rst)
    recv_valid && recv.count == lim_q && lim_q != CNT_ZERO);
  close_req_c: cover property (@(posedge sys_clk) disable iff (rst)
    closed_valid && closed.reason == RSN_CLOSE_REQUESTED);
  sense_c: cover property (@(posedge sys_clk) disable iff (rst)
    closed_valid && closed.reason == RSN_SENSE_DEASSERTED);
  fifo_full_c: cover property (@(posedge sys_clk) disable iff (rst)
    rx_valid && !rx_ready);
endmodule

// *** lrcr_host_model.sv ***
module lrcr_host_model import lrcr_pkg::*; (
  input wire logic sys_clk,
  input wire logic slow,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [CHAR_W-1:0] wr_data,
  input wire logic [CNT_W-1:0] wr_index,
  input wire logic closed_valid,
  output int nwr,
  output int close_events
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // Receive buffer of the port engine
  logic [1:0] phase = 2'h0;
  logic [CHAR_W-1:0] mem [64];
  initial nwr = 0;
  initial close_events = 0;
  // Slow mode refuses one cycle in three, so delivery must stall cleanly
  assign wr_ready = !slow || (phase != 2'h2);
  always @(posedge sys_clk) begin
    phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
    // Characters land at their index, merged or split freely
    // Ready is judged when the port takes a character, so every write lands
    if (wr_valid) begin
      mem[wr_index[5:0]] <= wr_data;
      nwr <= nwr + 1;
    end
    // A closed indication becomes a close event
    if (closed_valid) begin
      close_events <= close_events + 1;
    end
  end
endmodule

// *** test_link_receive_close_reset_services.sv ***
module test_link_receive_close_reset_services import lrcr_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk, rst, req_valid, rsp_valid, connected_valid, wr_valid;
  logic wr_ready, recv_valid, closed_valid, reset_rcvd_valid, rx_valid;
  logic rx_ready, tx_idle, cable_sense_a, transport_lost, slow;
  logic remote_reset_in, remote_reset_out;
  logic cable_sense_d, lib_closed_valid;
  lrcr_rsp_e lib_rsp;
  lrcr_req_s req;
  lrcr_rsp_e rsp;
  lrcr_recv_s recv, last_recv;
  lrcr_closed_s closed, last_closed;
  logic [CONN_W-1:0] connected_conn, cid;
  logic [CHAR_W-1:0] wr_data, rx_data, bid;
  logic [CNT_W-1:0] wr_index;
  logic [PORT_W-1:0] reset_rcvd_port;
  int failures, num_checks, recv_cnt, closed_cnt, rr_cnt, n, n0, c0;
  int lib_closed_cnt;

  lrcr_port u_dut (.sys_clk(sys_clk), .rst(rst), .req_valid(req_valid),
    .req(req), .rsp_valid(rsp_valid), .rsp(rsp),
    .connected_valid(connected_valid), .connected_conn(connected_conn),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
    .wr_index(wr_index), .recv_valid(recv_valid), .recv(recv),
    .closed_valid(closed_valid), .closed(closed),
    .reset_rcvd_valid(reset_rcvd_valid), .reset_rcvd_port(reset_rcvd_port),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
    .tx_idle(tx_idle), .cable_sense_a(cable_sense_a),
    .cable_sense_d(cable_sense_d),
    .transport_lost(transport_lost), .remote_reset_in(remote_reset_in),
    .remote_reset_out(remote_reset_out));
  lrcr_host_model u_host (.sys_clk(sys_clk), .slow(slow),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
    .wr_index(wr_index), .closed_valid(closed_valid), .nwr(),
    .close_events());
  // Library-side port: its remote reset line drives the drive-side pin
  lrcr_port #(.DRIVE_SIDE(1'b0)) u_lib (.sys_clk(sys_clk), .rst(rst),
    .req_valid(req_valid), .req(req), .rsp_valid(), .rsp(lib_rsp),
    .connected_valid(), .connected_conn(), .wr_valid(), .wr_ready(1'b1),
    .wr_data(), .wr_index(), .recv_valid(), .recv(),
    .closed_valid(lib_closed_valid), .closed(), .reset_rcvd_valid(),
    .reset_rcvd_port(), .rx_valid(rx_valid), .rx_ready(),
    .rx_data(rx_data), .tx_idle(tx_idle), .cable_sense_a(cable_sense_a),
    .cable_sense_d(cable_sense_d), .transport_lost(transport_lost),
    .remote_reset_in(1'b0), .remote_reset_out(remote_reset_in));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // ==========================================================
  // Indication monitor: pulses last one cycle, so latch them here
  always @(posedge sys_clk) begin
    if (recv_valid) begin
      recv_cnt++;
      last_recv = recv;
    end
    if (closed_valid) begin
      closed_cnt++;
      last_closed = closed;
    end
    if (reset_rcvd_valid) rr_cnt++;
    if (lib_closed_valid) lib_closed_cnt++;
  end
  // ==========================================================
  // Shared tasks
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rq(input lrcr_cmd_e c, input logic [CONN_W-1:0] cn,
                    input logic ok, input logic [CNT_W-1:0] lim,
                    input lrcr_rsp_e ex);
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req <= '{cmd: c, port: 4'h0, conn: cn, buf_id: bid, buf_ok: ok,
             limit: lim};
    @(posedge sys_clk);
    req_valid <= 1'b0;
    #1;
    chk("rsp_valid", 32'h1, {31'h0, rsp_valid});
    chk("rsp", {29'h0, ex}, {29'h0, rsp});
  endtask
  task automatic push(input int cnt, input logic [7:0] d0, output int took);
    int w;
    logic ok;
    took = 0;
    @(posedge sys_clk);
    for (int i = 0; i < cnt; i++) begin
      rx_valid <= 1'b1;
      rx_data <= d0 + 8'(i);
      w = 0;
      #1;
      while (!rx_ready && w < 4) begin
        @(posedge sys_clk);
        #1;
        w++;
      end
      ok = rx_ready;
      @(posedge sys_clk);
      if (ok) took++;
    end
    rx_valid <= 1'b0;
  endtask
  task automatic wait_for(ref int cnt, input int want);
    for (int k = 0; k < 400 && cnt < want; k++) @(posedge sys_clk);
    #1;
    chk("indication count", want, cnt);
  endtask
  task automatic open_conn;
    cid = cid + 4'h1;
    rq(CMD_OPEN, 4'h0, 1'b1, 16'h0000, RSP_GOOD);
    chk("connected", {27'h0, 1'b1, cid}, {27'h0, connected_valid,
        connected_conn});
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_receive;
    open_conn();
    push(3, 8'h7d, n);
    slow <= 1'b1;
    bid = 8'h31;
    rq(CMD_RECEIVE, cid, 1'b1, 16'h0002, RSP_GOOD);
    rq(CMD_RECEIVE, cid, 1'b1, 16'h0008, RSP_RECEIVE_PENDING);
    wait_for(recv_cnt, 1);
    chk("count", 32'h2, {16'h0, last_recv.count});
    chk("buf conn", {20'h0, cid, 8'h31}, {20'h0, last_recv.conn,
        last_recv.buf_id});
    chk("raw chars", 32'h7d7e, {16'h0, u_host.mem[0], u_host.mem[1]});
    rq(CMD_RECEIVE, cid, 1'b1, 16'h0008, RSP_GOOD);
    wait_for(recv_cnt, 2);
    chk("partial", 32'h00017f00, {last_recv.count, u_host.mem[0],
        8'h00});
    rq(CMD_RECEIVE, cid, 1'b1, 16'h0000, RSP_GOOD);
    wait_for(recv_cnt, 3);
    chk("zero limit", 32'h0, {16'h0, last_recv.count});
    rq(CMD_RECEIVE, cid, 1'b0, 16'h0004, RSP_INVALID_BUF);
    rq(CMD_RECEIVE, cid + 4'h1, 1'b1, 16'h0004, RSP_INVALID_CONN);
  endtask
  task automatic t_fifo;
    push(FIFO_DEPTH + 1, 8'h00, n);
    chk("fifo accepted", FIFO_DEPTH, n);
    rq(CMD_RECEIVE, cid, 1'b1, 16'h0028, RSP_GOOD);
    wait_for(recv_cnt, 4);
    chk("drained", FIFO_DEPTH, {16'h0, last_recv.count});
    chk("last char", 32'h1f, {24'h0, u_host.mem[31]});
  endtask
  task automatic t_close;
    push(2, 8'h41, n);
    tx_idle <= 1'b0;
    c0 = closed_cnt;
    rq(CMD_CLOSE, cid, 1'b1, 16'h0000, RSP_GOOD);
    rq(CMD_SEND, cid, 1'b1, 16'h0001, RSP_INVALID_CONN);
    rq(CMD_CLOSE, cid, 1'b1, 16'h0000, RSP_INVALID_CONN);
    repeat (20) @(posedge sys_clk);
    chk("closed early", c0, closed_cnt);
    rq(CMD_RECEIVE, cid, 1'b1, 16'h0004, RSP_GOOD);
    wait_for(recv_cnt, 5);
    chk("late count", 32'h2, {16'h0, last_recv.count});
    repeat (10) @(posedge sys_clk);
    chk("tx busy", c0, closed_cnt);
    tx_idle <= 1'b1;
    wait_for(closed_cnt, c0 + 1);
    chk("reason", {26'h0, cid, 2'(RSN_CLOSE_REQUESTED)}, {26'h0,
        last_closed});
    chk("close event", c0 + 1, u_host.close_events);
    rq(CMD_RECEIVE, cid, 1'b1, 16'h0004, RSP_INVALID_CONN);
    repeat (5) @(posedge sys_clk);
    chk("no recv", 32'h5, recv_cnt);
  endtask
  task automatic t_sense;
    open_conn();
    push(1, 8'h55, n);
    c0 = closed_cnt;
    transport_lost <= 1'b1;
    @(posedge sys_clk);
    transport_lost <= 1'b0;
    repeat (8) @(posedge sys_clk);
    chk("no lost close", c0, closed_cnt);
    cable_sense_a <= 1'b0;
    cable_sense_d <= 1'b0;
    wait_for(closed_cnt, c0 + 1);
    chk("sense reason", {26'h0, cid, 2'(RSN_SENSE_DEASSERTED)}, {26'h0,
        last_closed});
    wait_for(lib_closed_cnt, c0 + 1);
    repeat (20) @(posedge sys_clk);
    chk("one close", c0 + 1, closed_cnt);
    cable_sense_a <= 1'b1;
    cable_sense_d <= 1'b1;
    repeat (8) @(posedge sys_clk);
  endtask
  task automatic t_reset;
    rq(CMD_OPEN, 4'h0, 1'b1, 16'h0000, RSP_GOOD);
    chk("lib open", {29'h0, RSP_GOOD}, {29'h0, lib_rsp});
    rq(CMD_RESET, 4'h0, 1'b1, 16'h0000, RSP_INVALID_PORT);
    chk("lib reset rsp", {29'h0, RSP_GOOD}, {29'h0, lib_rsp});
    chk("lib remote out", 32'h1, {31'h0, remote_reset_in});
    wait_for(rr_cnt, 1);
    chk("reset port", 32'h0, {28'h0, reset_rcvd_port});
    chk("remote out", 32'h0, {31'h0, remote_reset_out});
    repeat (110) @(posedge sys_clk);
    #1;
    chk("lib remote end", 32'h0, {31'h0, remote_reset_in});
    rq(CMD_OPEN, 4'h0, 1'b1, 16'h0000, RSP_GOOD);
    chk("lib reopen", {29'h0, RSP_GOOD}, {29'h0, lib_rsp});
  endtask
  // ==========================================================
  // Verdict and main sequence
  task automatic results;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    results();
  end
  initial begin
    {rst, req_valid, rx_valid, tx_idle, cable_sense_a} = 5'h13;
    {transport_lost, cable_sense_d, slow} = 3'h2;
    req = '0;
    rx_data = 8'h00;
    {failures, num_checks, recv_cnt, closed_cnt, rr_cnt, lib_closed_cnt} = '0;
    cid = 4'h0;
    bid = 8'h00;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (6) @(posedge sys_clk);
    t_receive();
    t_fifo();
    t_close();
    t_sense();
    t_reset();
    results();
  end
endmodule
